// ### src/video_rx_consts.svh
// Register offsets, reset values and pin function codes of the video receiver control bank.
// Assumes inclusion by bare name from the package and the register bank.
`ifndef VIDEO_RX_CONSTS_SVH
`define VIDEO_RX_CONSTS_SVH

`define A_EDH_FF     8'h01
`define A_EDH_AP     8'h02
`define A_EDH_ANC    8'h03
`define A_ANC_STAT   8'h04
`define A_ID_LO      8'h05
`define A_ID_HI      8'h06
`define A_MASK_LO    8'h07
`define A_MASK_HI    8'h08
`define A_TEST       8'h0d
`define A_VINFO      8'h0e
`define A_PIN_FIRST  8'h0f
`define A_PIN_LAST   8'h16
`define A_ANC_CTL    8'h17
`define A_VCTL       8'h55
`define A_REFCLK     8'h67

`define R_ON         1'h1
`define R_OFF        1'h0
`define R_ANC_ID     16'h0000
`define R_ANC_MASK   16'hffff
`define R_PATTERN    6'h00
`define R_REFCLK     2'h0
`define R_DEPTH      3'h0
`define R_BYTE       8'h00

`define NUM_PINS     8
`define SEL_W        6
`define LOCK_PIN     3'h4
`define EMPTY_PIN    3'h6

`define F_NONE       6'h00
`define F_LOCK       6'h01
`define F_EMPTY      6'h02
`define F_FULL       6'h03
`define F_CRC        6'h04
`define F_PASS       6'h05
`define F_MSG        6'h06
`define I_DDITH      6'h20
`define I_VDITH      6'h21
`define I_PGEN       6'h22
`define I_PFILT      6'h23
`define I_PAT0       6'h28
`endif

// ### src/video_rx_pkg.sv
// Types shared by the video receiver control bank.
// Assumes the constants header sits beside it.
`include "video_rx_consts.svh"
package video_rx_pkg;
    typedef logic [7:0]                      reg_byte_t;
    typedef logic [`SEL_W-1:0]               pin_sel_t;
    typedef logic [`NUM_PINS*`SEL_W-1:0]     pin_cfg_t;
    typedef logic [`NUM_PINS-1:0]            pin_vec_t;
endpackage

// ### src/video_rx_control_register_bank.sv
// Configuration and status register bank of a serial video receiver, with multifunction pin routing.
// Assumes status inputs come from datapath logic on clk and the pin bus comes from outside.
`timescale 1ns/100ps
`include "video_rx_consts.svh"
module video_rx_control_register_bank
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [7:0]                 addr,
    input  wire logic [7:0]                 wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic [7:0]                      rdata,
    input  wire logic                       lock_detect,
    input  wire logic                       pass_fail,
    input  wire logic                       crc_error,
    input  wire logic                       crc_error_luma,
    input  wire logic                       crc_error_chroma,
    input  wire logic [4:0]                 ff_flags,
    input  wire logic [4:0]                 ap_flags,
    input  wire logic [4:0]                 anc_flags,
    input  wire logic                       ff_flag_error,
    input  wire logic                       ap_flag_error,
    input  wire logic                       anc_flag_error,
    input  wire logic                       anc_fifo_overrun,
    input  wire logic                       anc_fifo_empty,
    input  wire logic                       anc_fifo_full,
    input  wire logic                       checksum_error,
    input  wire logic                       full_message_available,
    input  wire logic [7:0]                 io_in,
    output logic [7:0]                      io_out,
    output logic [7:0]                      io_oe,
    output logic                            lsb_clip_en,
    output logic                            sync_detect_en,
    output logic                            dedither_en,
    output logic                            vert_dedither_en,
    output logic                            bypass_descramble,
    output logic [5:0]                      pattern_select,
    output logic                            pattern_generator_en,
    output logic                            pattern_filter_enable,
    output logic [1:0]                      ref_clock_sel,
    output logic                            external_vclk_sel,
    output logic                            edh_force,
    output logic                            edh_enable,
    output logic                            crc_replace,
    output logic [2:0]                      video_fifo_depth,
    output logic                            checksum_force,
    output logic [15:0]                     anc_id,
    output logic [15:0]                     anc_mask,
    output logic                            fifo_extract_en,
    output logic                            fifo_clock_en,
    output logic                            fifo_flush_static,
    output logic                            message_flush_static,
    output logic                            message_tracking
);

    // Select code of pin i.
    function automatic video_rx_pkg::pin_sel_t pin_sel(input video_rx_pkg::pin_cfg_t cfg, input int i);
        pin_sel = cfg[i*`SEL_W +: `SEL_W];
    endfunction

    // Returns {hit, level}: the lowest pin carrying the input function wins.
    function automatic logic [1:0] pin_in(input video_rx_pkg::pin_cfg_t cfg,
                                          input video_rx_pkg::pin_vec_t pins,
                                          input video_rx_pkg::pin_sel_t code);
        logic [1:0] res;
        res = 2'h0;
        for (int i = `NUM_PINS - 1; i >= 0; i--)
        begin
            if (pin_sel(cfg, i) == code)
            begin
                res = {1'h1, pins[i]};
            end
        end
        return res;
    endfunction

    // Control bit as seen by the datapath: a configured pin overrides the register.
    function automatic logic ctl_eff(input logic [1:0] hit_val, input logic reg_val);
        ctl_eff = hit_val[1] ? hit_val[0] : reg_val;
    endfunction

    // Register state.
    logic                          lsb_clip_reg, lsb_clip_next;
    logic                          sync_det_reg, sync_det_next;
    logic                          ddith_reg, ddith_next;
    logic                          vddith_reg, vddith_next;
    logic                          bypass_reg, bypass_next;
    logic [5:0]                    pattern_reg, pattern_next;
    logic                          pgen_reg, pgen_next;
    logic                          pfilt_reg, pfilt_next;
    logic [1:0]                    refclk_reg, refclk_next;
    logic                          vclk_reg, vclk_next;
    logic                          edh_force_reg, edh_force_next;
    logic                          edh_en_reg, edh_en_next;
    logic                          crc_repl_reg, crc_repl_next;
    logic [2:0]                    depth_reg, depth_next;
    logic                          cks_force_reg, cks_force_next;
    logic [15:0]                   id_reg, id_next;
    logic [15:0]                   mask_reg, mask_next;
    logic                          extract_reg, extract_next;
    logic                          fclk_reg, fclk_next;
    logic                          fflush_reg, fflush_next;
    logic                          mflush_reg, mflush_next;
    logic                          mtrack_reg, mtrack_next;
    video_rx_pkg::pin_cfg_t        pin_cfg_reg, pin_cfg_next;
    video_rx_pkg::reg_byte_t       rdata_reg, rdata_next;

    // Pin synchroniser and output stage.
    video_rx_pkg::pin_vec_t        io_meta_reg;
    video_rx_pkg::pin_vec_t        io_sync_reg;
    video_rx_pkg::pin_vec_t        io_out_reg, io_out_next;
    video_rx_pkg::pin_vec_t        io_oe_reg, io_oe_next;
    logic                          ddith_o_reg, ddith_o_next;
    logic                          vddith_o_reg, vddith_o_next;
    logic                          pgen_o_reg, pgen_o_next;
    logic                          pfilt_o_reg, pfilt_o_next;
    logic [5:0]                    pattern_o_reg, pattern_o_next;

    logic                          wr_pin;
    logic [2:0]                    wr_pin_idx;
    logic [7:0]                    pin_off;

    assign pin_off    = addr - `A_PIN_FIRST;
    assign wr_pin     = wr && (addr >= `A_PIN_FIRST) && (addr <= `A_PIN_LAST);
    assign wr_pin_idx = pin_off[2:0];

    // Software writes. Reserved positions are simply never loaded.
    always_comb
    begin
        lsb_clip_next  = lsb_clip_reg;
        sync_det_next  = sync_det_reg;
        ddith_next     = ddith_reg;
        vddith_next    = vddith_reg;
        bypass_next    = bypass_reg;
        pattern_next   = pattern_reg;
        pgen_next      = pgen_reg;
        pfilt_next     = pfilt_reg;
        refclk_next    = refclk_reg;
        vclk_next      = vclk_reg;
        edh_force_next = edh_force_reg;
        edh_en_next    = edh_en_reg;
        crc_repl_next  = crc_repl_reg;
        depth_next     = depth_reg;
        cks_force_next = cks_force_reg;
        id_next        = id_reg;
        mask_next      = mask_reg;
        extract_next   = extract_reg;
        fclk_next      = fclk_reg;
        fflush_next    = fflush_reg;
        mflush_next    = mflush_reg;
        mtrack_next    = mtrack_reg;
        pin_cfg_next   = pin_cfg_reg;
        if (wr)
        begin
            unique case (addr)
                `A_EDH_FF:
                begin
                    edh_force_next = wdata[6];
                    edh_en_next    = wdata[5];
                end
                `A_EDH_AP:   crc_repl_next = wdata[7];
                `A_ANC_STAT:
                begin
                    depth_next     = wdata[7:5];
                    cks_force_next = wdata[0];
                end
                `A_ID_LO:    id_next[7:0]    = wdata;
                `A_ID_HI:    id_next[15:8]   = wdata;
                `A_MASK_LO:  mask_next[7:0]  = wdata;
                `A_MASK_HI:  mask_next[15:8] = wdata;
                `A_TEST:
                begin
                    pgen_next    = wdata[6];
                    pattern_next = wdata[5:0];
                end
                `A_VINFO:
                begin
                    ddith_next  = wdata[7];
                    vddith_next = wdata[6];
                    pfilt_next  = wdata[5];
                end
                `A_ANC_CTL:
                begin
                    extract_next = wdata[7];
                    fclk_next    = wdata[6];
                    fflush_next  = wdata[3];
                    mflush_next  = wdata[1];
                    mtrack_next  = wdata[0];
                end
                `A_VCTL:
                begin
                    vclk_next     = wdata[6];
                    sync_det_next = wdata[5];
                    lsb_clip_next = wdata[4];
                    bypass_next   = wdata[0];
                end
                `A_REFCLK:   refclk_next = wdata[2:1];
                default:
                begin
                end
            endcase
            if (wr_pin)
            begin
                pin_cfg_next[wr_pin_idx*`SEL_W +: `SEL_W] = wdata[5:0];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lsb_clip_reg  <= `R_ON;
            sync_det_reg  <= `R_ON;
            ddith_reg     <= `R_OFF;
            vddith_reg    <= `R_OFF;
            bypass_reg    <= `R_OFF;
            pattern_reg   <= `R_PATTERN;
            pgen_reg      <= `R_OFF;
            pfilt_reg     <= `R_OFF;
            refclk_reg    <= `R_REFCLK;
            vclk_reg      <= `R_OFF;
            edh_force_reg <= `R_OFF;
            edh_en_reg    <= `R_ON;
            crc_repl_reg  <= `R_OFF;
            depth_reg     <= `R_DEPTH;
            cks_force_reg <= `R_OFF;
            id_reg        <= `R_ANC_ID;
            mask_reg      <= `R_ANC_MASK;
            extract_reg   <= `R_OFF;
            fclk_reg      <= `R_OFF;
            fflush_reg    <= `R_OFF;
            mflush_reg    <= `R_OFF;
            mtrack_reg    <= `R_OFF;
            pin_cfg_reg   <= {`F_NONE, `F_EMPTY, `F_NONE, `F_LOCK,
                              `F_NONE, `F_NONE, `F_NONE, `F_NONE};
        end
        else
        begin
            lsb_clip_reg  <= lsb_clip_next;
            sync_det_reg  <= sync_det_next;
            ddith_reg     <= ddith_next;
            vddith_reg    <= vddith_next;
            bypass_reg    <= bypass_next;
            pattern_reg   <= pattern_next;
            pgen_reg      <= pgen_next;
            pfilt_reg     <= pfilt_next;
            refclk_reg    <= refclk_next;
            vclk_reg      <= vclk_next;
            edh_force_reg <= edh_force_next;
            edh_en_reg    <= edh_en_next;
            crc_repl_reg  <= crc_repl_next;
            depth_reg     <= depth_next;
            cks_force_reg <= cks_force_next;
            id_reg        <= id_next;
            mask_reg      <= mask_next;
            extract_reg   <= extract_next;
            fclk_reg      <= fclk_next;
            fflush_reg    <= fflush_next;
            mflush_reg    <= mflush_next;
            mtrack_reg    <= mtrack_next;
            pin_cfg_reg   <= pin_cfg_next;
        end
    end

    // Read port: data appear only in the cycle after the strobe; unmapped and reserved read zero.
    always_comb
    begin
        rdata_next = `R_BYTE;
        if (rd)
        begin
            unique case (addr)
                `A_EDH_FF:   rdata_next = {crc_error, edh_force_reg, edh_en_reg, ff_flags};
                `A_EDH_AP:   rdata_next = {crc_repl_reg, crc_error_luma, crc_error_chroma, ap_flags};
                `A_EDH_ANC:  rdata_next = {ff_flag_error, ap_flag_error, anc_flag_error, anc_flags};
                `A_ANC_STAT: rdata_next = {depth_reg, anc_fifo_overrun, anc_fifo_empty,
                                           anc_fifo_full, checksum_error, cks_force_reg};
                `A_ID_LO:    rdata_next = id_reg[7:0];
                `A_ID_HI:    rdata_next = id_reg[15:8];
                `A_MASK_LO:  rdata_next = mask_reg[7:0];
                `A_MASK_HI:  rdata_next = mask_reg[15:8];
                `A_TEST:     rdata_next = {pass_fail, pgen_reg, pattern_reg};
                `A_VINFO:    rdata_next = {ddith_reg, vddith_reg, pfilt_reg, lock_detect, 4'h0};
                `A_ANC_CTL:  rdata_next = {extract_reg, fclk_reg, full_message_available,
                                           1'h0, fflush_reg, 1'h0, mflush_reg, mtrack_reg};
                `A_VCTL:     rdata_next = {1'h0, vclk_reg, sync_det_reg, lsb_clip_reg, 3'h0, bypass_reg};
                `A_REFCLK:   rdata_next = {5'h00, refclk_reg, 1'h0};
                default:
                begin
                    if ((addr >= `A_PIN_FIRST) && (addr <= `A_PIN_LAST))
                    begin
                        rdata_next = {2'h0, pin_sel(pin_cfg_reg, int'(pin_off[2:0]))};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata_reg <= `R_BYTE;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // Pin inputs arrive from outside, so two flops stand before any pin logic.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            io_meta_reg <= `R_BYTE;
            io_sync_reg <= `R_BYTE;
        end
        else
        begin
            io_meta_reg <= io_in;
            io_sync_reg <= io_meta_reg;
        end
    end

    // Pin routing. A pin carrying an input function is never driven, which avoids contention
    // with whatever drives it from outside.
    always_comb
    begin
        io_out_next    = `R_BYTE;
        io_oe_next     = `R_BYTE;
        for (int i = 0; i < `NUM_PINS; i++)
        begin
            io_oe_next[i] = 1'h1;
            unique case (pin_sel(pin_cfg_reg, i))
                `F_LOCK:  io_out_next[i] = lock_detect;
                `F_EMPTY: io_out_next[i] = anc_fifo_empty;
                `F_FULL:  io_out_next[i] = anc_fifo_full;
                `F_CRC:   io_out_next[i] = crc_error;
                `F_PASS:  io_out_next[i] = pass_fail;
                `F_MSG:   io_out_next[i] = full_message_available;
                default:  io_oe_next[i]  = 1'h0;
            endcase
        end
        ddith_o_next  = ctl_eff(pin_in(pin_cfg_reg, io_sync_reg, `I_DDITH), ddith_reg);
        vddith_o_next = ctl_eff(pin_in(pin_cfg_reg, io_sync_reg, `I_VDITH), vddith_reg);
        pgen_o_next   = ctl_eff(pin_in(pin_cfg_reg, io_sync_reg, `I_PGEN), pgen_reg);
        pfilt_o_next  = ctl_eff(pin_in(pin_cfg_reg, io_sync_reg, `I_PFILT), pfilt_reg);
        for (int b = 0; b < `SEL_W; b++)
        begin
            pattern_o_next[b] = ctl_eff(pin_in(pin_cfg_reg, io_sync_reg,
                                               `I_PAT0 + video_rx_pkg::pin_sel_t'(b)), pattern_reg[b]);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            io_out_reg    <= `R_BYTE;
            io_oe_reg     <= `R_BYTE;
            ddith_o_reg   <= `R_OFF;
            vddith_o_reg  <= `R_OFF;
            pgen_o_reg    <= `R_OFF;
            pfilt_o_reg   <= `R_OFF;
            pattern_o_reg <= `R_PATTERN;
        end
        else
        begin
            io_out_reg    <= io_out_next;
            io_oe_reg     <= io_oe_next;
            ddith_o_reg   <= ddith_o_next;
            vddith_o_reg  <= vddith_o_next;
            pgen_o_reg    <= pgen_o_next;
            pfilt_o_reg   <= pfilt_o_next;
            pattern_o_reg <= pattern_o_next;
        end
    end

    assign rdata                 = rdata_reg;
    assign io_out                = io_out_reg;
    assign io_oe                 = io_oe_reg;
    assign lsb_clip_en           = lsb_clip_reg;
    assign sync_detect_en        = sync_det_reg;
    assign dedither_en           = ddith_o_reg;
    assign vert_dedither_en      = vddith_o_reg;
    assign bypass_descramble     = bypass_reg;
    assign pattern_select        = pattern_o_reg;
    assign pattern_generator_en  = pgen_o_reg;
    assign pattern_filter_enable = pfilt_o_reg;
    assign ref_clock_sel         = refclk_reg;
    assign external_vclk_sel     = vclk_reg;
    assign edh_force             = edh_force_reg;
    assign edh_enable            = edh_en_reg;
    assign crc_replace           = crc_repl_reg;
    assign video_fifo_depth      = depth_reg;
    assign checksum_force        = cks_force_reg;
    assign anc_id                = id_reg;
    assign anc_mask              = mask_reg;
    assign fifo_extract_en       = extract_reg;
    assign fifo_clock_en         = fclk_reg;
    assign fifo_flush_static     = fflush_reg;
    assign message_flush_static  = mflush_reg;
    assign message_tracking      = mtrack_reg;

endmodule // video_rx_control_register_bank

// ### test/video_rx_checker.sv
// Concurrent checks on the ports of the video receiver control bank.
// Assumes one clock and a synchronous active-high reset; bound to the bank at the foot.
`timescale 1ns/100ps
module video_rx_checker
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    input wire logic [7:0]  io_oe,
    input wire logic        lsb_clip_en,
    input wire logic        sync_detect_en,
    input wire logic        edh_enable,
    input wire logic [15:0] anc_id,
    input wire logic [15:0] anc_mask,
    input wire logic        fifo_extract_en,
    input wire logic        message_tracking
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_clip_reset: assert property ($fell(rst) |-> lsb_clip_en && sync_detect_en)
        else $error("clip or sync enable not set after reset");
    a_id_reset: assert property ($fell(rst) |-> anc_id == 16'h0000 && anc_mask == 16'hffff)
        else $error("id or mask wrong after reset");
    a_lock_pin: assert property ($fell(rst) |-> ##[0:2] io_oe == 8'h50)
        else $error("status pins not driven after reset");
    a_id_low_write: assert property (wr && addr == 8'h05 |=> anc_id[7:0] == $past(wdata))
        else $error("id low byte not written");
    a_mask_high_write: assert property (wr && addr == 8'h08 |=> anc_mask[15:8] == $past(wdata))
        else $error("mask high byte not written");
    a_id_read: assert property (rd && addr == 8'h05 |=> rdata == anc_id[7:0])
        else $error("id low byte read wrong");
    a_edh_read: assert property (rd && addr == 8'h01 |=> rdata[5] == edh_enable)
        else $error("edh enable read wrong");
    a_ctl_reserved: assert property (rd && addr == 8'h17 |=> rdata[4] == 1'h0 && rdata[2] == 1'h0)
        else $error("reserved control bits read nonzero");
    a_ctl_write: assert property (wr && addr == 8'h17 |=> {fifo_extract_en, message_tracking} ==
        {$past(wdata[7]), $past(wdata[0])}) else $error("fifo control bits not written");
endmodule // video_rx_checker

bind video_rx_control_register_bank video_rx_checker i_video_rx_checker (.clk, .rst, .addr, .wdata, .wr, .rd,
    .rdata, .io_oe, .lsb_clip_en, .sync_detect_en, .edh_enable, .anc_id, .anc_mask, .fifo_extract_en,
    .message_tracking);

// ### test/video_rx_control_register_bank_tb_top.sv
// Register-level testbench of the video receiver control bank.
// Assumes the checker is bound in its own file; status inputs come from one bench vector.
`timescale 1ns/100ps
module video_rx_control_register_bank_tb_top;
    logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, io_in = 8'h00, rdata, io_out, io_oe;
    logic [31:0] s = 32'h00000000;
    logic [15:0] anc_id, anc_mask;
    logic dedither_en;
    wire [26:0] ctl;
    int fail_count = 0, checks = 0;
    logic [7:0] ra[12] = '{8'h01, 8'h55, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0d, 8'h0e, 8'h67, 8'h13, 8'h15, 8'h09};
    logic [7:0] re[12] = '{8'h20, 8'h30, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00};
    logic [7:0] sa[7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h17, 8'h0e, 8'h0d};
    logic [7:0] se[7] = '{8'hbf, 8'h7f, 8'hff, 8'h1e, 8'h20, 8'h10, 8'h80};
    logic [7:0] wa[11] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h17, 8'h04, 8'h55, 8'h67, 8'h0f, 8'h0d, 8'h0e};
    logic [7:0] wd[11] = '{8'ha5, 8'h3c, 8'h0f, 8'h81, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h60};
    logic [7:0] we[11] = '{8'ha5, 8'h3c, 8'h0f, 8'h81, 8'hcb, 8'he1, 8'h71, 8'h06, 8'h3f, 8'h7f, 8'h60};
    initial forever #2.5 clk = ~clk;
    video_rx_control_register_bank i_video_rx_control_register_bank (.clk, .rst, .addr, .wdata, .wr, .rd,
        .rdata, .lock_detect(s[0]), .pass_fail(s[1]), .crc_error(s[2]), .crc_error_luma(s[3]),
        .crc_error_chroma(s[4]), .ff_flags(s[9:5]), .ap_flags(s[14:10]), .anc_flags(s[19:15]),
        .ff_flag_error(s[20]), .ap_flag_error(s[21]), .anc_flag_error(s[22]), .anc_fifo_overrun(s[23]),
        .anc_fifo_empty(s[24]), .anc_fifo_full(s[25]), .checksum_error(s[26]), .full_message_available(s[27]),
        .io_in, .io_out, .io_oe, .lsb_clip_en(ctl[0]), .sync_detect_en(ctl[1]), .dedither_en,
        .vert_dedither_en(ctl[2]), .bypass_descramble(ctl[3]), .pattern_select(ctl[9:4]),
        .pattern_generator_en(ctl[10]), .pattern_filter_enable(ctl[11]), .ref_clock_sel(ctl[13:12]),
        .external_vclk_sel(ctl[14]), .edh_force(ctl[15]), .edh_enable(ctl[16]), .crc_replace(ctl[17]),
        .video_fifo_depth(ctl[20:18]), .checksum_force(ctl[21]), .anc_id, .anc_mask,
        .fifo_extract_en(ctl[22]), .fifo_clock_en(ctl[23]), .fifo_flush_static(ctl[24]),
        .message_flush_static(ctl[25]), .message_tracking(ctl[26]));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 cmp({8'h00, rdata}, {8'h00, e});
    endtask
    task automatic finish_test;
        if (fail_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 0;
        repeat (2) @(posedge clk);
        #1 cmp({8'h00, io_oe}, 16'h0050);
        cmp(ctl[15:0], 16'h0003);
        cmp({5'h00, ctl[26:16]}, 16'h0001);
        for (int i = 0; i < 12; i++) rd_chk(ra[i], re[i]);
        s <= 32'hffffffff;
        for (int i = 0; i < 7; i++) rd_chk(sa[i], se[i]);
        @(posedge clk);
        #1 cmp({8'h00, io_out}, 16'h0050);
        s <= 32'h00000000;
        for (int i = 0; i < 11; i++) wr_reg(wa[i], wd[i]);
        for (int i = 0; i < 11; i++) rd_chk(wa[i], we[i]);
        cmp(anc_id, 16'h3ca5);
        cmp(anc_mask, 16'h810f);
        cmp(ctl[15:0], 16'h7fff);
        cmp({5'h00, ctl[26:16]}, 16'h07fd);
        wr_reg(8'h0f, 8'h20);
        io_in <= 8'h01;
        // Two sync flops plus the override stage.
        repeat (4) @(posedge clk);
        #1 cmp({14'h0000, dedither_en, io_oe[0]}, 16'h0002);
        // Status outputs on the spare pins, and pin 7 pulls the pattern generator enable low.
        s <= 32'h0a000006;
        wr_reg(8'h10, 8'h03);
        wr_reg(8'h11, 8'h04);
        wr_reg(8'h12, 8'h05);
        wr_reg(8'h14, 8'h06);
        wr_reg(8'h16, 8'h22);
        repeat (4) @(posedge clk);
        #1 cmp({io_oe, io_out}, 16'h7e2e);
        cmp(ctl[15:0], 16'h7bff);
        // A second reset must restore every default, pin routing included.
        @(posedge clk);
        rst <= 1'h1;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        repeat (2) @(posedge clk);
        #1 cmp({io_oe, io_out}, 16'h5000);
        cmp(ctl[15:0], 16'h0003);
        cmp({5'h00, ctl[26:16]}, 16'h0001);
        cmp(anc_id, 16'h0000);
        cmp(anc_mask, 16'hffff);
        finish_test();
    end
endmodule // video_rx_control_register_bank_tb_top
